/* File: logic/dovc_pkg.sv */
// Purpose: constants for the oscillator and core voltage control block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: the status word layout and the level codes are local choices
// Overview of operation
// R01: control bit 3 picks the cpu clock, one fast, zero slow; reads back.
// R02: control bit 2 turns the fast oscillator on or off; reads back.
// R03: bits 1..0 pick core voltage: 00 low, 01 middle, 1x high.
// R04: reset clears the whole control register: slow clock, fast off, low voltage.
// R05: software passes through 01 for over 5 ms between 00 and 1x.
// R06: software waits at least 5 ms after enabling fast oscillator before selecting it.
// R07: software raises voltage, then enables fast oscillator, then switches clock.
// R08: software uses middle voltage near 1 MHz, high voltage at 2 MHz.
// R09: on slow clock, low voltage below 3.1 V supply, middle at or above.
// R10: software may keep low voltage on slow clock for supplies at most 3.6 V.
// R11: software changes voltage only after detector shows supply above new setting.
// R12: software switches clock to slow and disables fast oscillator in separate writes.
// R13: with the resistor-capacitor slow oscillator option, 00 gives middle voltage.
// R14: instructions last 5, 7 or 12 cycles of the selected system clock.
// R15: software sets voltage from supply level at start of initialisation.
// R16: without speed need, software runs slow, stops fast oscillator, keeps low or middle voltage.
// R17: the clock switch never truncates or merges pulses and settles within few cycles; here a switch to a stopped oscillator waits until it runs.
package dovc_pkg;
  localparam logic [11:0] DOVC_CTRL_ADDR = 12'hf70;
  localparam logic [11:0] DOVC_STATUS_ADDR = 12'hf74;
  localparam logic [3:0] DOVC_CTRL_RESET = 4'h0;
  localparam int DOVC_CLK_SEL_BIT = 3;
  localparam int DOVC_FAST_EN_BIT = 2;
  localparam int DOVC_VSEL_HI_BIT = 1;
  localparam int DOVC_VSEL_LO_BIT = 0;
  localparam int DOVC_ST_ACTIVE_BIT = 0;
  localparam int DOVC_ST_SWITCH_BIT = 1;
  localparam int DOVC_ST_INSTR_BIT = 2;
  localparam int DOVC_ST_LEVEL_LSB = 4;
  localparam logic [3:0] DOVC_INSTR_SHORT = 4'h5;
  localparam logic [3:0] DOVC_INSTR_MID = 4'h7;
  localparam logic [3:0] DOVC_INSTR_LONG = 4'hc;
  // core supply level codes
  localparam logic [1:0] DOVC_LEVEL_1V2 = 2'h0;
  localparam logic [1:0] DOVC_LEVEL_2V1 = 2'h1;
  localparam logic [1:0] DOVC_LEVEL_3V0 = 2'h2;
  typedef enum logic [1:0]
  {
    DOVC_SW_RUN = 2'b00,
    DOVC_SW_DRAIN = 2'b01,
    DOVC_SW_ARM = 2'b10
  } dovc_switch_type;
endpackage

/* File: logic/dovc_top.sv */
// Purpose: register, clock source switch and core level select for the dual oscillator
// Assumes: oscillator outputs arrive as pins asynchronous to hclk and far slower than it
// Notes: the cpu clock is delivered as a one-cycle enable pulse on hclk
//   a switch to an oscillator that never runs waits for it; starting it first is up to software
//   voltage ordering and settle waits are software duties and are not enforced here
`timescale 1ns/1ps
module dovc_top
  import dovc_pkg::*;
#(
  parameter int ARM_EDGES = 2
)
(
  input wire logic hclk, // bus and sampling clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  input wire logic slow_oscillator, // slow oscillator output pin
  input wire logic fast_oscillator, // fast oscillator output pin
  input wire logic rc_slow_osc_option, // strap: slow oscillator is resistor-capacitor type
  output logic fast_osc_enable, // run the fast oscillator
  output logic cpu_clock_select, // requested cpu clock source
  output logic core_voltage_sel_hi, // voltage select high bit
  output logic core_voltage_sel_lo, // voltage select low bit
  output logic [1:0] core_supply_level, // effective core level code
  output logic cpu_clk_en, // one pulse per selected system clock cycle
  output logic active_clock_fast, // source now driving the cpu clock
  input wire logic instr_start, // pulse: begin an instruction
  input wire logic [1:0] instr_class, // 0 short, 1 mid, 2 long
  output logic instr_busy, // instruction in progress
  output logic instr_done // pulse: instruction finished
);

  if (ARM_EDGES < 1 || ARM_EDGES > 15)
  begin : g_bad_arm
    $error("ARM_EDGES must be 1..15");
  end

  // a zero length would wrap the instruction counter and run sixteen cycles
  if (DOVC_INSTR_SHORT == 4'h0 || DOVC_INSTR_MID == 4'h0 || DOVC_INSTR_LONG == 4'h0)
  begin : g_bad_len
    $error("instruction lengths must be nonzero");
  end

  function automatic logic [3:0] dovc_instr_len(input logic [1:0] cls);
    case (cls)
      2'h0: dovc_instr_len = DOVC_INSTR_SHORT;
      2'h1: dovc_instr_len = DOVC_INSTR_MID;
      default: dovc_instr_len = DOVC_INSTR_LONG;
    endcase
  endfunction

  // high bit wins; the resistor-capacitor option lifts the low setting to the middle one
  function automatic logic [1:0] dovc_level(input logic [3:0] c, input logic rc);
    if (c[DOVC_VSEL_HI_BIT])
      dovc_level = DOVC_LEVEL_3V0; // [R03]
    else if (c[DOVC_VSEL_LO_BIT] || rc)
      dovc_level = DOVC_LEVEL_2V1; // [R03] [R13]
    else
      dovc_level = DOVC_LEVEL_1V2;
  endfunction

  logic [3:0] ctrl_reg;
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  logic [1:0] osc_s1_reg;
  logic [1:0] osc_s2_reg;
  logic [1:0] osc_s3_reg;
  logic [1:0] osc_rise;
  logic [1:0] osc_fall;
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic rc_opt_reg;
  logic strap_done_reg;
  dovc_switch_type sw_reg;
  logic active_reg;
  logic [3:0] arm_cnt_reg;
  logic clk_en_reg;
  logic [3:0] instr_cnt_reg;
  logic instr_pend_reg;
  logic instr_done_reg;
  logic addr_phase;
  logic ctrl_wr;
  logic [3:0] ctrl_fwd;
  logic [11:0] rd_addr;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  // zero wait states: every register answers in the cycle after its address
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;
  assign ctrl_wr = wr_pend_reg && addr_reg == DOVC_CTRL_ADDR;

  // bus: address phase captured, write lands at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end
    else if (hready)
    begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        addr_reg <= {haddr[11:2], 2'b00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= DOVC_CTRL_RESET; // [R04]
    else if (ctrl_wr)
      ctrl_reg <= hwdata[3:0]; // [R01] [R02] [R03]
  end

  // read word is registered at the end of the address phase; a write still in
  // its data phase is forwarded so a read right behind it sees the new value
  assign rd_addr = {haddr[11:2], 2'b00};
  assign ctrl_fwd = ctrl_wr ? hwdata[3:0] : ctrl_reg;

  // unmapped words read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (rd_addr == DOVC_CTRL_ADDR)
      rdata_next[3:0] = ctrl_fwd; // [R01] [R02]
    else if (rd_addr == DOVC_STATUS_ADDR)
    begin
      rdata_next[DOVC_ST_ACTIVE_BIT] = active_reg;
      rdata_next[DOVC_ST_SWITCH_BIT] = (sw_reg != DOVC_SW_RUN);
      rdata_next[DOVC_ST_INSTR_BIT] = instr_pend_reg;
      rdata_next[DOVC_ST_LEVEL_LSB +: 2] = dovc_level(ctrl_fwd, rc_opt_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_reg <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      rdata_reg <= rdata_next;
  end

  assign hrdata = rdata_reg;

  assign cpu_clock_select = ctrl_reg[DOVC_CLK_SEL_BIT];
  assign fast_osc_enable = ctrl_reg[DOVC_FAST_EN_BIT];
  assign core_voltage_sel_hi = ctrl_reg[DOVC_VSEL_HI_BIT];
  assign core_voltage_sel_lo = ctrl_reg[DOVC_VSEL_LO_BIT];

  // strap synchroniser, then copied every cycle from the second cycle after reset release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      rc_opt_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      strap_s1_reg <= rc_slow_osc_option;
      strap_s2_reg <= strap_s1_reg;
      strap_done_reg <= 1'b1;
      if (strap_done_reg)
        rc_opt_reg <= strap_s2_reg;
    end
  end

  assign core_supply_level = dovc_level(ctrl_reg, rc_opt_reg); // [R03] [R13]

  // oscillator synchronisers: index 0 slow, 1 fast; edges only from stage two onward
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_s1_reg <= 2'b00;
      osc_s2_reg <= 2'b00;
      osc_s3_reg <= 2'b00;
    end
    else
    begin
      osc_s1_reg <= {fast_oscillator, slow_oscillator};
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  assign osc_rise = osc_s2_reg & ~osc_s3_reg;
  assign osc_fall = ~osc_s2_reg & osc_s3_reg;

  // switch: stop after the old source's low edge, let the new one run a few whole
  // periods before handing it the cpu, so no pulse is cut short or two are merged
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sw_reg <= DOVC_SW_RUN;
      active_reg <= 1'b0;
      arm_cnt_reg <= 4'h0;
    end
    else
    begin
      unique case (sw_reg)
        DOVC_SW_RUN:
        begin
          if (cpu_clock_select != active_reg)
            sw_reg <= DOVC_SW_DRAIN; // [R17]
        end
        DOVC_SW_DRAIN:
        begin
          if (osc_fall[active_reg])
          begin
            sw_reg <= DOVC_SW_ARM; // [R17]
            arm_cnt_reg <= 4'h0;
          end
        end
        DOVC_SW_ARM:
        begin
          if (cpu_clock_select == active_reg)
            sw_reg <= DOVC_SW_RUN;
          else if (osc_rise[cpu_clock_select])
          begin
            if (arm_cnt_reg == 4'(ARM_EDGES - 1))
            begin
              active_reg <= cpu_clock_select; // [R17]
              sw_reg <= DOVC_SW_RUN;
            end
            else
              arm_cnt_reg <= arm_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // switching takes effect on the new source's edge after arming
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clk_en_reg <= 1'b0;
    else
      clk_en_reg <= (sw_reg == DOVC_SW_RUN) & osc_rise[active_reg]; // [R01] [R17]
  end

  assign cpu_clk_en = clk_en_reg;
  assign active_clock_fast = active_reg;

  // instruction timer counts selected system clock cycles; a start while busy is
  // dropped, not queued, but one in the done cycle is taken
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_cnt_reg <= 4'h0;
      instr_pend_reg <= 1'b0;
      instr_done_reg <= 1'b0;
    end
    else
    begin
      instr_done_reg <= 1'b0;
      if (!instr_pend_reg)
      begin
        if (instr_start)
        begin
          instr_pend_reg <= 1'b1;
          instr_cnt_reg <= dovc_instr_len(instr_class); // [R14]
        end
      end
      else if (clk_en_reg)
      begin
        if (instr_cnt_reg == 4'h1)
        begin
          instr_pend_reg <= 1'b0;
          instr_done_reg <= 1'b1; // [R14]
        end
        instr_cnt_reg <= instr_cnt_reg - 4'h1;
      end
    end
  end

  assign instr_busy = instr_pend_reg;
  assign instr_done = instr_done_reg;

endmodule

/* File: test/dovc_monitor.sv */
// Purpose: port checks for dovc_top
// Assumes: one clock, asynchronous active-low reset
// Notes: register bus traffic is judged by the bench
`timescale 1ns/1ps
module dovc_monitor
  import dovc_pkg::*;
(
  input wire logic hclk, // clock
  input wire logic hresetn, // reset
  input wire logic rc_slow_osc_option, // strap
  input wire logic fast_osc_enable, // ctrl bit2
  input wire logic cpu_clock_select, // ctrl bit3
  input wire logic core_voltage_sel_hi, // ctrl bit1
  input wire logic core_voltage_sel_lo, // ctrl bit0
  input wire logic [1:0] core_supply_level, // level
  input wire logic cpu_clk_en, // clock pulse
  input wire logic active_clock_fast, // source
  input wire logic instr_busy, // busy
  input wire logic instr_done // done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_hi; core_voltage_sel_hi |-> core_supply_level == DOVC_LEVEL_3V0; endproperty
  // the strap is synchronised, so judge it only once it has sat still a while
  property p_low; $stable(rc_slow_osc_option)[*8] ##0 !(core_voltage_sel_hi || core_voltage_sel_lo)
    |-> core_supply_level == {1'b0, rc_slow_osc_option}; endproperty
  property p_rst; $rose(hresetn) |-> !{cpu_clock_select, fast_osc_enable,
    core_voltage_sel_hi, core_voltage_sel_lo, active_clock_fast}; endproperty
  property p_pulse; cpu_clk_en |=> !cpu_clk_en; endproperty
  property p_sw; $changed(active_clock_fast) |-> active_clock_fast == cpu_clock_select; endproperty
  property p_rise; $rose(active_clock_fast) |-> fast_osc_enable; endproperty
  property p_done; instr_done |-> $past(cpu_clk_en) && $past(instr_busy); endproperty
  a_hi: assert property (p_hi) else $error("high level wrong");
  a_low: assert property (p_low) else $error("low level wrong");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_pulse: assert property (p_pulse) else $error("merged clock pulse");
  a_sw: assert property (p_sw) else $error("source flipped wrongly");
  a_rise: assert property (p_rise) else $error("switched to stopped source");
  a_done: assert property (p_done) else $error("done without clock pulse");
  cover property ($rose(active_clock_fast));
  cover property ($fell(active_clock_fast));
  cover property (instr_done);
endmodule
bind dovc_top dovc_monitor u_mon (.*);

/* File: test/dovc_top_tb.sv */
// Purpose: self-checking bench for dovc_top
// Assumes: oscillator pins far faster than real parts
// Notes: settle waits shortened to 60 cycles to keep runs short
`timescale 1ns/1ps
module dovc_top_tb;
  import dovc_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'he042a2ff;
  logic [1:0] htrans = 2'h0, instr_class = 2'h0, core_supply_level;
  logic [2:0] hsize = 3'h2;
  logic slow_oscillator = 1'h0, fast_oscillator = 1'h0, rc_slow_osc_option = 1'h0, instr_start = 1'h0;
  logic fast_osc_enable, cpu_clock_select, core_voltage_sel_hi, core_voltage_sel_lo, cpu_clk_en;
  logic active_clock_fast, instr_busy, instr_done;
  logic [3:0] v, pins;
  int err_count = 0, n_compared = 0;
  assign hready = hreadyout;
  assign pins = {cpu_clock_select, fast_osc_enable, core_voltage_sel_hi, core_voltage_sel_lo};
  dovc_top #(.ARM_EDGES(2)) u_dut (.*);
  always #20 hclk = ~hclk;
  always #397.7 slow_oscillator = ~slow_oscillator;
  // a disabled fast oscillator sits low, so a switch to it must wait
  always #113.3 fast_oscillator = fast_osc_enable & ~fast_oscillator;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] exp_lvl(input logic [3:0] c, input logic rc);
    return c[1] ? DOVC_LEVEL_3V0 : (c[0] || rc) ? DOVC_LEVEL_2V1 : DOVC_LEVEL_1V2;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    err_count += (g !== e);
    if (g !== e)
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic wait_src(input logic s);
    for (int n = 0; n < 300 && active_clock_fast !== s; n++)
      @(posedge hclk);
    chk("active source", s, active_clock_fast);
  endtask
  task automatic run_instr(input logic [1:0] c);
    int k = 0;
    instr_class <= c;
    instr_start <= 1'h1;
    @(posedge hclk);
    instr_start <= 1'h0;
    for (int n = 0; n < 500 && instr_done !== 1'h1; n++)
    begin
      @(negedge hclk);
      if (n == 0)
        chk("instr busy", 32'h1, instr_busy);
      k += (cpu_clk_en === 1'h1 && instr_done !== 1'h1);
    end
    chk("idle at done", 32'h0, instr_busy);
    // hand back on a rising edge so the next driver starts there
    @(posedge hclk);
    chk("instr clocks", c == 2'h0 ? DOVC_INSTR_SHORT : c == 2'h1 ? DOVC_INSTR_MID : DOVC_INSTR_LONG, k);
  endtask
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, 32'hf70, 32'h0);
    chk("ctrl at reset", 32'h0, rd);
    // voltage steps always pass through 01 between 00 and 1x; the supply is taken as above every setting
    for (int i = 0; i < 16; i++)
    begin
      rc_slow_osc_option <= i > 7 && i < 15;
      seed = xs(seed);
      v = 4'((16'h46e4 >> (2 * (i % 8))) & 16'h3);
      bus(1'h1, 32'hf70, {seed[31:4], v});
      bus(1'h0, 32'hf70, 32'h0);
      chk("ctrl", {28'h0, v}, rd);
      chk("ctrl pins", {28'h0, v}, {28'h0, pins});
      chk("level", exp_lvl(v, rc_slow_osc_option), core_supply_level);
    end
    bus(1'h0, 32'hf78, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    bus(1'h1, 32'hf70, 32'h5);
    repeat (60) @(posedge hclk);
    bus(1'h1, 32'hf70, 32'hd);
    bus(1'h0, 32'hf70, 32'h0);
    chk("ctrl fast", 32'hd, rd);
    wait_src(1'h1);
    bus(1'h0, 32'hf74, 32'h0);
    chk("status", {26'h0, DOVC_LEVEL_2V1, 4'h1}, rd);
    for (int c = 0; c < 8; c++)
    begin
      if (c == 4)
      begin
        bus(1'h1, 32'hf70, 32'h5);
        wait_src(1'h0);
        bus(1'h1, 32'hf70, 32'h1);
      end
      seed = xs(seed);
      run_instr(c < 4 ? 2'(c) : seed[1:0]);
    end
    $display("test clock switch done");
    tally_and_finish();
  end
  initial
  begin
    #1_000_000;
    err_count++;
    tally_and_finish();
  end
endmodule
